// ==== src/adc_seq_pkg.sv ====
package adc_seq_pkg;
   localparam int RES_W = 10;
   localparam int NCH   = 8;
   localparam int CNT_W = 5;
   localparam int PAD_W = 16 - RES_W;

   localparam logic [7:0] OFS_CTL2     = 8'h00;
   localparam logic [7:0] OFS_CTL3     = 8'h04;
   localparam logic [7:0] OFS_CTL4     = 8'h08;
   localparam logic [7:0] OFS_CTL5     = 8'h0c;
   localparam logic [7:0] OFS_STAT     = 8'h10;
   localparam logic [7:0] OFS_TEST     = 8'h14;
   localparam logic [7:0] OFS_MASK     = 8'h18;
   localparam logic [7:0] OFS_RES0     = 8'h20;
   localparam logic [7:0] OFS_RES_LAST = 8'h3c;
   localparam int RES_IDX_LO = 2;
   localparam int RES_IDX_HI = 4;

   localparam int C2_HALT   = 0;
   localparam int C2_JUST   = 1;
   localparam int C2_SGN    = 2;
   localparam int C3_SINGLE = 0;
   localparam int C3_FIFO   = 1;
   localparam int C5_CH_HI  = 2;
   localparam int C5_SPEC   = 3;
   localparam int C5_MULT   = 4;
   localparam int C5_SCAN   = 5;
   localparam int C5_EIGHT  = 6;
   localparam int ST_SCF    = 0;
   localparam int ST_CCF    = 1;
   localparam int ST_BUSY   = 7;
   localparam int TEST_SRST = 15;

   localparam logic [2:0] CTL2_RST = 3'h0;
   localparam logic [1:0] CTL3_RST = 2'h0;
   localparam logic [3:0] CTL4_RST = 4'h0;
   localparam logic [6:0] CTL5_RST = 7'h00;
   localparam logic [1:0] MASK_RST = 2'h0;

   localparam logic [CNT_W-1:0] SETTLE_BASE = 5'h03;
   localparam logic [3:0] LEN_ONE   = 4'h1;
   localparam logic [3:0] LEN_FOUR  = 4'h4;
   localparam logic [3:0] LEN_EIGHT = 4'h8;
   localparam logic [RES_W-1:0] SIGN_BIT = 10'h200;

   typedef enum logic [1:0] {SQ_IDLE, SQ_START, SQ_CONV} seq_e;
endpackage

// ==== src/adc_sequence_control.sv ====
`timescale 1ns/100ps
module adc_sequence_control (
   input  wire logic                          hclk,
   input  wire logic                          hresetn,
   input  wire logic                          ce,
   input  wire logic                          hsel,
   input  wire logic [31:0]                   haddr,
   input  wire logic [1:0]                    htrans,
   input  wire logic                          hwrite,
   input  wire logic [2:0]                    hsize,
   input  wire logic [31:0]                   hwdata,
   input  wire logic                          hready,
   output logic                               hreadyout,
   output logic                               hresp,
   output logic      [31:0]                   hrdata,
   input  wire logic                          cmp_in,
   input  wire logic                          wait_mode,
   output logic      [3:0]                    analog_channel,
   output logic      [adc_seq_pkg::RES_W-1:0] dac_code,
   output logic                               conv_busy,
   output logic                               irq
);
   import adc_seq_pkg::*;

   typedef struct packed {
      logic [2:0]                ctl2;
      logic [1:0]                ctl3;
      logic [3:0]                ctl4;
      logic [6:0]                ctl5;
      logic [1:0]                stat;
      logic [1:0]                mask;
      logic [NCH-1:0][15:0]      res;
      seq_e                      seq;
      logic [2:0]                idx;
      logic [2:0]                wptr;
      logic [3:0]                chan;
      logic                      eng_start;
      logic                      eng_clr;
      logic                      a_act;
      logic                      a_wr;
      logic [7:0]                a_addr;
      logic                      rd_wait;
      logic [31:0]               rdata;
   } state_s;

   state_s           s_r;
   state_s           s_nxt;
   logic             cmp_s;
   logic [RES_W-1:0] sar;
   logic             eng_busy;
   logic             eng_done;
   logic             run;
   logic             bus_wr;
   logic             rd_cap;
   logic             last;
   logic [1:0]       ev;
   logic [1:0]       clr;

   function automatic logic [3:0] seq_len(input logic [1:0] c3,
                                          input logic [6:0] c5);
      if (c3[C3_SINGLE]) begin
         return LEN_ONE;
      end
      return c5[C5_EIGHT] ? LEN_EIGHT : LEN_FOUR;
   endfunction

   function automatic logic [3:0] chan_of(input logic [6:0] c5,
                                          input logic [2:0] i);
      logic [2:0] ch;
      ch = c5[C5_CH_HI:0];
      if (c5[C5_MULT]) begin
         ch = ch + i;
      end
      return {c5[C5_SPEC], ch};
   endfunction

   function automatic logic [15:0] fmt(input logic [RES_W-1:0] raw,
                                       input logic [2:0]       c2);
      logic [RES_W-1:0] v;
      logic             ext;
      v   = c2[C2_SGN] ? (raw ^ SIGN_BIT) : raw;
      ext = c2[C2_SGN] & v[RES_W-1];
      if (c2[C2_JUST]) begin
         return {{PAD_W{ext}}, v};
      end
      return {v, {PAD_W{1'b0}}};
   endfunction

   function automatic logic [31:0] rd_mux(input state_s           s,
                                          input logic [RES_W-1:0] sv);
      logic [31:0] r;
      r = '0;
      case (s.a_addr)
         OFS_CTL2: r = 32'(s.ctl2);
         OFS_CTL3: r = 32'(s.ctl3);
         OFS_CTL4: r = 32'(s.ctl4);
         OFS_CTL5: r = 32'(s.ctl5);
         OFS_STAT: begin
            r          = 32'(s.stat);
            r[ST_BUSY] = s.seq != SQ_IDLE;
         end
         OFS_TEST: r = 32'(sv);
         OFS_MASK: r = 32'(s.mask);
         default: begin
            if (s.a_addr >= OFS_RES0 && s.a_addr <= OFS_RES_LAST) begin
               r = 32'(s.res[s.a_addr[RES_IDX_HI:RES_IDX_LO]]);
            end
         end
      endcase
      return r;
   endfunction

   bit_sync #(
      .W (1)
   ) u_cmp_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .ce      (ce),
      .d       (cmp_in),
      .q       (cmp_s)
   );

   sar_engine #(
      .W  (RES_W),
      .CW (CNT_W)
   ) u_sar (
      .hclk    (hclk),
      .hresetn (hresetn),
      .ce      (ce),
      .run     (run),
      .start   (s_r.eng_start),
      .clr     (s_r.eng_clr),
      .settle  (SETTLE_BASE + CNT_W'(s_r.ctl4)),
      .cmp     (cmp_s),
      .sar     (sar),
      .busy    (eng_busy),
      .done    (eng_done)
   );

   assign run    = !(s_r.ctl2[C2_HALT] && wait_mode);
   assign bus_wr = s_r.a_act && s_r.a_wr;
   assign rd_cap = s_r.a_act && !s_r.a_wr && !s_r.rd_wait;
   // Single bit set mid-sequence ends it after the current conversion, no wrap
   assign last   = ({1'b0, s_r.idx} + 4'h1) >= seq_len(s_r.ctl3, s_r.ctl5);

   always_comb begin
      s_nxt           = s_r;
      s_nxt.eng_start = 1'b0;
      s_nxt.eng_clr   = 1'b0;
      ev              = '0;
      clr             = '0;

      // Bus: address phase capture, one wait state on reads
      if (hready) begin
         s_nxt.a_act   = hsel && htrans[1];
         s_nxt.a_wr    = hwrite;
         s_nxt.a_addr  = haddr[7:0];
         s_nxt.rd_wait = 1'b0;
      end
      if (rd_cap) begin
         s_nxt.rd_wait = 1'b1;
         s_nxt.rdata   = rd_mux(s_r, sar);
         if (s_r.a_addr == OFS_STAT) begin
            clr = 2'h3;
         end
      end

      case (s_r.seq)
         SQ_IDLE: begin
         end
         SQ_START: begin
            if (run) begin
               s_nxt.eng_start = 1'b1;
               s_nxt.chan      = chan_of(s_r.ctl5, s_r.idx);
               s_nxt.seq       = SQ_CONV;
            end
         end
         SQ_CONV: begin
            if (eng_done) begin
               ev[ST_CCF] = 1'b1;
               if (s_r.ctl3[C3_FIFO]) begin
                  s_nxt.res[s_r.wptr] = fmt(sar, s_r.ctl2);
                  s_nxt.wptr          = s_r.wptr + 3'h1;
               end else begin
                  s_nxt.res[s_r.idx] = fmt(sar, s_r.ctl2);
               end
               // Length from single and eight bits
               if (last) begin
                  // Flag at end of every sequence
                  ev[ST_SCF] = 1'b1;
                  s_nxt.idx  = '0;
                  s_nxt.seq  = s_r.ctl5[C5_SCAN] ? SQ_START : SQ_IDLE;
               end else begin
                  s_nxt.idx = s_r.idx + 3'h1;
                  s_nxt.seq = SQ_START;
               end
            end
         end
         default: begin
            s_nxt.seq = SQ_IDLE;
         end
      endcase

      if (bus_wr) begin
         case (s_r.a_addr)
            OFS_CTL2: s_nxt.ctl2 = hwdata[2:0];
            OFS_CTL3: s_nxt.ctl3 = hwdata[1:0];
            OFS_CTL4: begin
               s_nxt.ctl4    = hwdata[3:0];
               s_nxt.idx     = '0;
               s_nxt.seq     = SQ_START;
               // Stale done must not land in the new sequence
               s_nxt.eng_clr = 1'b1;
            end
            OFS_CTL5: begin
               s_nxt.ctl5    = hwdata[6:0];
               s_nxt.idx     = '0;
               s_nxt.wptr    = '0;
               s_nxt.seq     = SQ_START;
               s_nxt.eng_clr = 1'b1;
               clr           = 2'h3;
            end
            OFS_TEST: begin
               if (hwdata[TEST_SRST]) begin
                  s_nxt.eng_clr = 1'b1;
                  s_nxt.idx     = '0;
                  s_nxt.wptr    = '0;
                  s_nxt.seq     = SQ_IDLE;
                  clr           = 2'h3;
               end
            end
            OFS_MASK: s_nxt.mask = hwdata[1:0];
            default: begin
            end
         endcase
      end

      // Set wins over clear so no completion is lost
      s_nxt.stat = (s_r.stat & ~clr) | ev;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r      <= '0;
         s_r.ctl2 <= CTL2_RST;
         s_r.ctl3 <= CTL3_RST;
         s_r.ctl4 <= CTL4_RST;
         s_r.ctl5 <= CTL5_RST;
         s_r.mask <= MASK_RST;
         s_r.seq  <= SQ_IDLE;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign hreadyout      = !rd_cap;
   assign hresp          = 1'b0;
   assign hrdata         = s_r.rdata;
   assign analog_channel = s_r.chan;
   assign dac_code       = sar;
   assign conv_busy      = eng_busy;
   assign irq            = |(s_r.stat & s_r.mask);

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   AST_CTL4_RESTART: assert property (
      ce && bus_wr && s_r.a_addr == OFS_CTL4
      |=> s_r.seq == SQ_START && s_r.idx == 3'h0)
      else $error("control four write did not restart");

   AST_CTL5_CLEAR: assert property (
      ce && bus_wr && s_r.a_addr == OFS_CTL5 && !eng_done
      |=> s_r.stat == 2'h0 && s_r.seq == SQ_START)
      else $error("control five write did not clear and restart");

   AST_CFG_NO_ABORT: assert property (
      ce && bus_wr && s_r.seq == SQ_CONV && !eng_done
      && (s_r.a_addr == OFS_CTL2 || s_r.a_addr == OFS_CTL3)
      |=> s_r.seq == SQ_CONV)
      else $error("config write aborted a sequence");

   AST_SCAN_FLAG: assert property (
      ce && !bus_wr && !rd_cap && s_r.seq == SQ_CONV && eng_done
      && last && s_r.ctl5[C5_SCAN]
      |=> (s_r.stat[ST_SCF] && s_r.seq == SQ_START)
      and (ce && run |=> s_r.eng_start))
      else $error("scan sequence end did not flag and restart");

   AST_TEST_READ: assert property (
      ce && rd_cap && s_r.a_addr == OFS_TEST
      |=> hrdata == 32'($past(sar)) && hreadyout)
      else $error("test register read not approximation value");

   AST_SOFT_RESET: assert property (
      ce && bus_wr && s_r.a_addr == OFS_TEST && hwdata[TEST_SRST]
      && !eng_done
      |=> s_r.seq == SQ_IDLE && s_r.stat == 2'h0 && s_r.eng_clr)
      else $error("soft reset did not reset converter");

   AST_SINGLE_LEN: assert property (
      ce && !bus_wr && s_r.seq == SQ_CONV && eng_done
      && s_r.ctl3[C3_SINGLE] && !s_r.ctl5[C5_SCAN]
      |=> s_r.seq == SQ_IDLE && s_r.stat[ST_SCF])
      else $error("single conversion did not end sequence");

   AST_START_CHAN: assert property (
      ce && run && !bus_wr && s_r.seq == SQ_START && s_r.idx == 3'h0
      |=> s_r.eng_start
      && s_r.chan == {$past(s_r.ctl5[C5_SPEC]), $past(s_r.ctl5[C5_CH_HI:0])})
      else $error("sequence did not start at selected channel");

   AST_WAIT_HALT: assert property (
      ce && !run && !bus_wr && s_r.seq == SQ_START
      |=> s_r.seq == SQ_START && !s_r.eng_start)
      else $error("conversion started while halted in wait");
endmodule

// ==== src/bit_sync.sv ====
`timescale 1ns/100ps
module bit_sync #(
   parameter int W = 1
) (
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stab;
   } sync_s;

   sync_s s_r;
   sync_s s_nxt;

   always_comb begin
      s_nxt      = s_r;
      s_nxt.meta = d;
      s_nxt.stab = s_r.meta;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r <= '0;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign q = s_r.stab;
endmodule

// ==== src/sar_engine.sv ====
`timescale 1ns/100ps
module sar_engine #(
   parameter int W  = adc_seq_pkg::RES_W,
   parameter int CW = adc_seq_pkg::CNT_W
) (
   input  wire logic          hclk,
   input  wire logic          hresetn,
   input  wire logic          ce,
   input  wire logic          run,
   input  wire logic          start,
   input  wire logic          clr,
   input  wire logic [CW-1:0] settle,
   input  wire logic          cmp,
   output logic      [W-1:0]  sar,
   output logic               busy,
   output logic               done
);
   import adc_seq_pkg::*;
   localparam int BW = $clog2(W);

   typedef struct packed {
      logic          busy;
      logic          done;
      logic [BW-1:0] bitn;
      logic [CW-1:0] cnt;
      logic [W-1:0]  sar;
   } eng_s;

   eng_s s_r;
   eng_s s_nxt;

   always_comb begin
      s_nxt      = s_r;
      s_nxt.done = 1'b0;
      if (clr) begin
         s_nxt.busy = 1'b0;
         s_nxt.sar  = '0;
      end else if (start) begin
         s_nxt.busy       = 1'b1;
         s_nxt.bitn       = BW'(W - 1);
         s_nxt.cnt        = settle;
         s_nxt.sar        = '0;
         s_nxt.sar[W-1]   = 1'b1;
      end else if (s_r.busy && run) begin
         // Settle covers the two-stage comparator synchroniser
         if (s_r.cnt != '0) begin
            s_nxt.cnt = s_r.cnt - 1'b1;
         end else begin
            if (!cmp) begin
               s_nxt.sar[s_r.bitn] = 1'b0;
            end
            if (s_r.bitn == '0) begin
               s_nxt.busy = 1'b0;
               s_nxt.done = 1'b1;
            end else begin
               s_nxt.bitn                = s_r.bitn - 1'b1;
               s_nxt.sar[s_r.bitn-1'b1]  = 1'b1;
               s_nxt.cnt                 = settle;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r <= '0;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign sar  = s_r.sar;
   assign busy = s_r.busy;
   assign done = s_r.done;
endmodule

// ==== testbench/analog_front_end.sv ====
`timescale 1ns/100ps
module analog_front_end
   import adc_seq_pkg::*;
(
   input  wire logic [3:0]                    analog_channel,
   input  wire logic [adc_seq_pkg::RES_W-1:0] dac_code,
   input  wire logic [adc_seq_pkg::RES_W-1:0] level_base,
   output logic                               cmp_in
);
   logic [RES_W-1:0] level;

   // Distinct level per input, so a wrong channel pick shows in results
   assign level  = level_base + {analog_channel, 6'h2d};
   assign cmp_in = (level >= dac_code);
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
   import adc_seq_pkg::*;
   logic             hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp;
   logic             cmp_in, wait_mode, conv_busy, irq;
   logic [1:0]       htrans;
   logic [2:0]       hsize;
   logic [31:0]      haddr, hwdata, hrdata, q;
   logic [3:0]       analog_channel;
   logic [RES_W-1:0] dac_code, level_base, last_raw, d0;
   logic [31:0]      exp_q[$];
   int               n_errors, n_tests, seed, k;
   logic [2:0]       t2[5] = '{3'h0, 3'h2, 3'h6, 3'h4, 3'h2};
   logic [1:0]       t3[5] = '{2'h0, 2'h0, 2'h2, 2'h1, 2'h2};
   logic [6:0]       t5[5] = '{7'h10, 7'h15, 7'h53, 7'h5e, 7'h0a};
   logic [7:0]       ra[6] = '{OFS_CTL2, OFS_CTL3, OFS_CTL4, OFS_CTL5,
                               OFS_MASK, 8'h40};

   adc_sequence_control DUT (
      .hclk           (hclk),
      .hresetn        (hresetn),
      .ce             (ce),
      .hsel           (hsel),
      .haddr          (haddr),
      .htrans         (htrans),
      .hwrite         (hwrite),
      .hsize          (hsize),
      .hwdata         (hwdata),
      .hready         (hreadyout),
      .hreadyout      (hreadyout),
      .hresp          (hresp),
      .hrdata         (hrdata),
      .cmp_in         (cmp_in),
      .wait_mode      (wait_mode),
      .analog_channel (analog_channel),
      .dac_code       (dac_code),
      .conv_busy      (conv_busy),
      .irq            (irq)
   );

   analog_front_end front (
      .analog_channel (analog_channel),
      .dac_code       (dac_code),
      .level_base     (level_base),
      .cmp_in         (cmp_in)
   );

   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   // Entered just after a rising edge; returns just after one
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      logic r;
      int   n;
      haddr  <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      n = 0;
      do begin
         @(negedge hclk);
         r = hreadyout;
         @(posedge hclk);
         n++;
      end while (r !== 1'b1 && n < 20);
      htrans <= 2'b00;
      hwdata <= d;
      n = 0;
      do begin
         @(negedge hclk);
         r = hreadyout;
         q = hrdata;
         @(posedge hclk);
         n++;
      end while (r !== 1'b1 && n < 20);
      if (r !== 1'b1) n_errors++;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, ~hwdata);
   endtask

   function automatic logic [RES_W-1:0] lvl(input logic [3:0] ch);
      lvl = level_base + {ch, 6'h2d};
   endfunction

   function automatic logic [31:0] fmt(input logic [RES_W-1:0] raw,
                                       input logic [2:0] c2);
      logic [RES_W-1:0] v;
      v = c2[C2_SGN] ? raw ^ SIGN_BIT : raw;
      if (!c2[C2_JUST]) fmt = {16'h0, v, 6'h00};
      else if (c2[C2_SGN]) fmt = {16'h0, {6{v[9]}}, v};
      else fmt = {16'h0, 6'h00, v};
   endfunction

   // Reference model: pushes the expected results of one sequence
   task automatic start_cfg(input logic [2:0] c2, input logic [1:0] c3,
                            input logic [6:0] c5, input logic [3:0] c4);
      int         n;
      logic [3:0] ch;
      level_base <= RES_W'($urandom_range(255));
      wr(OFS_CTL4, {28'h0, c4});
      wr(OFS_CTL2, {29'h0, c2});
      wr(OFS_CTL3, {30'h0, c3});
      wr(OFS_CTL5, {25'h0, c5});
      n = c3[C3_SINGLE] ? 1 : (c5[C5_EIGHT] ? 8 : 4);
      for (int i = 0; i < n; i++) begin
         ch = {c5[C5_SPEC], c5[C5_MULT] ? c5[2:0] + 3'(i) : c5[2:0]};
         last_raw = lvl(ch);
         exp_q.push_back(fmt(last_raw, c2));
      end
   endtask

   task automatic wait_scf;
      k = 0;
      do begin
         rd(OFS_STAT);
         k++;
      end while (q[ST_SCF] !== 1'b1 && k < 2000);
      if (k >= 2000) n_errors++;
   endtask

   task automatic finish_cfg;
      int i;
      wait_scf();
      i = 0;
      while (exp_q.size() > 0) begin
         rd(OFS_RES0 + 8'(4 * i));
         chk(q, exp_q.pop_front());
         i++;
      end
      rd(OFS_TEST);
      chk(q, {22'h0, last_raw});
   endtask

   initial begin
      repeat (40000) @(posedge hclk);
      $display("watchdog expired");
      n_errors++;
      end_sim();
   end

   initial begin
      hresetn    = 1'b0;
      ce         = 1'b1;
      hsel       = 1'b1;
      hsize      = 3'h2;
      haddr      = 32'h0;
      htrans     = 2'b00;
      hwrite     = 1'b0;
      hwdata     = 32'h0;
      wait_mode  = 1'b0;
      level_base = 10'h000;
      seed       = $urandom(32'hb869dbc0);
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);

      wr(8'h40, 32'hffff_ffff);
      foreach (ra[i]) begin
         rd(ra[i]);
         chk(q, 32'h0);
      end
      chk({31'h0, hresp}, 32'h0);
      $display("reset values done");

      foreach (t5[i]) begin
         start_cfg(t2[i], t3[i], t5[i], 4'($urandom_range(3)));
         finish_cfg();
      end
      $display("configurations done");

      // Scan of single conversions, completion flag unmasked
      wr(OFS_MASK, 32'h1);
      wr(OFS_CTL3, 32'h1);
      wr(OFS_CTL5, 32'h21);
      repeat (3) begin
         k = 0;
         do begin
            @(negedge hclk);
            k++;
         end while (irq !== 1'b1 && k < 2000);
         @(posedge hclk);
         rd(OFS_STAT);
         chk({31'h0, q[ST_SCF]}, 32'h1);
         @(negedge hclk);
         chk({31'h0, irq}, 32'h0);
         @(posedge hclk);
      end
      wr(OFS_MASK, 32'h0);
      repeat (300) @(posedge hclk);
      @(negedge hclk);
      chk({31'h0, irq}, 32'h0);
      @(posedge hclk);
      rd(OFS_STAT);
      chk({31'h0, q[ST_SCF]}, 32'h1);
      $display("scan and interrupt done");

      // Long bit time so the sequence is caught mid-way
      wr(OFS_CTL3, 32'h0);
      wr(OFS_CTL4, 32'hf);
      wr(OFS_CTL5, 32'h52);
      repeat (400) @(posedge hclk);
      wr(OFS_CTL2, 32'h2);
      repeat (4) @(posedge hclk);
      @(negedge hclk);
      chk({31'h0, analog_channel[2:0] == 3'h2}, 32'h0);
      @(posedge hclk);
      wr(OFS_CTL4, 32'hf);
      repeat (4) @(posedge hclk);
      @(negedge hclk);
      chk({28'h0, analog_channel}, 32'h2);
      chk({31'h0, conv_busy}, 32'h1);
      @(posedge hclk);
      repeat (300) @(posedge hclk);
      wr(OFS_CTL5, 32'h52);
      repeat (2) @(posedge hclk);
      rd(OFS_STAT);
      chk({30'h0, q[1:0]}, 32'h0);
      chk({28'h0, analog_channel}, 32'h2);
      $display("abort and restart done");

      wr(OFS_TEST, 32'h8000);
      repeat (100) @(posedge hclk);
      @(negedge hclk);
      chk({31'h0, conv_busy}, 32'h0);
      @(posedge hclk);
      rd(OFS_STAT);
      chk({31'h0, q[ST_BUSY]}, 32'h0);
      rd(OFS_CTL5);
      chk(q, 32'h52);
      $display("soft reset done");

      start_cfg(3'h1, 2'h0, 7'h10, 4'h0);
      repeat (20) @(posedge hclk);
      wait_mode <= 1'b1;
      repeat (2) @(posedge hclk);
      @(negedge hclk);
      d0 = dac_code;
      repeat (200) @(posedge hclk);
      @(negedge hclk);
      chk({22'h0, dac_code}, {22'h0, d0});
      @(posedge hclk);
      rd(OFS_STAT);
      chk({31'h0, q[ST_SCF]}, 32'h0);
      // Restart while halted waits for wake-up
      wr(OFS_CTL5, 32'h10);
      repeat (20) @(posedge hclk);
      @(negedge hclk);
      chk({31'h0, conv_busy}, 32'h0);
      @(posedge hclk);
      wait_mode <= 1'b0;
      finish_cfg();
      $display("halt in wait done");
      end_sim();
   end
endmodule
